/* File: hw/panel_pkg.sv */
// panel_pkg: shared constants and types of the front-panel menu controller
// assumes a 10 MHz system clock and an AHB-Lite master for the register bus
package panel_pkg;
    // clock and timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int DEBOUNCE_MS  = 10;
    localparam int IDLE_S       = 30;
    localparam int PHASE_MS     = 1000;
    localparam int MUTE_MS      = 1;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int IDLE_CYC     = CLK_HZ * IDLE_S;
    localparam int PHASE_CYC    = CLK_HZ / 1000 * PHASE_MS;
    localparam int MUTE_CYC     = CLK_HZ / 1000 * MUTE_MS;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_LEVEL   = 8'h08;
    localparam logic [7:0] OFS_SAVED   = 8'h0C;
    localparam logic [7:0] OFS_LIVE    = 8'h10;
    localparam logic [7:0] OFS_VERSION = 8'h14;
    // menu items in panel order
    localparam logic [2:0] MI_FREQ   = 3'h0;
    localparam logic [2:0] MI_GAIN   = 3'h1;
    localparam logic [2:0] MI_REMOTE = 3'h2;
    localparam logic [2:0] MI_SENSE  = 3'h3;
    localparam logic [2:0] MI_STEP   = 3'h4;
    localparam logic [2:0] MI_EXTREF = 3'h5;
    localparam logic [2:0] MI_SERIAL = 3'h6;
    localparam logic [2:0] MI_ADDR   = 3'h7;
    localparam logic [2:0] CUR_RET   = 3'h4;   // cursor on the return mark
    // value limits
    localparam logic [21:0] FREQ_MIN_KHZ = 22'h1E_8480;  // 2000000 kHz
    localparam logic [21:0] FREQ_MAX_KHZ = 22'h26_25A0;  // 2500000 kHz
    localparam logic [21:0] FREQ_RST_KHZ = 22'h1F_47D0;  // 2050000 kHz
    localparam logic [5:0]  GAIN_MAX_DB  = 6'h32;        // 50 dB
    localparam logic [1:0]  SER_LAST     = 2'h2;         // three standards
    localparam int          OUT_MAX_DBM  = 0;
    localparam int          OUT_MIN_DBM  = -20;
    // switch vector positions
    localparam int SW_SEL = 0;
    localparam int SW_LEFT = 1;
    localparam int SW_RIGHT = 2;
    localparam int SW_UP = 3;
    localparam int SW_DOWN = 4;
    localparam int SW_N = 5;

    typedef enum logic [2:0] {
        ST_LAMP, ST_VER, ST_READ, ST_MENU, ST_PROMPT, ST_DONE
    } state_t;

    // serial link: 9600 baud, 8N1 on every standard
    typedef enum logic [1:0] {SER_RS232, SER_RS422, SER_RS485} serial_t;

    typedef struct packed {
        logic [21:0] freq_khz;
        logic [5:0]  gain_db;
        logic        remote;
        logic        invert;
        logic [1:0]  step;     // 0:1 1:10 2:100 3:125 kHz
        logic        extref;
        logic [1:0]  serial;
        logic [4:0]  addr;     // multidrop only
    } settings_t;

    localparam settings_t SET_RST = '{FREQ_RST_KHZ, 6'h00, 1'b0, 1'b0,
                                      2'h0, 1'b0, 2'h0, 5'h00};
endpackage : panel_pkg

/* File: hw/front_panel_menu.sv */
// front_panel_menu: switch debounce, menu sequencer, save prompt,
// display state, settings apply/commit and AHB-Lite register slave
// assumes synchronous switch inputs, an external non-volatile store
// presenting its contents on nv_data, and one AHB-Lite master
// Operation
// - session opens with select, ends confirmed
// - thirty idle seconds abandon session, restore settings
// - saved settings kept, reloaded at power-up
// - power-up: lamp test, version, readout
// - eight menu items in fixed order
// - return mark or last item enters prompt
// - select advances to next menu item
// - horizontal rocker moves cursor left/right
// - vertical rocker steps frequency/gain digit
// - vertical rocker toggles on/off items
// - frequency applied only after yes
// - carrier muted when yes changes tuned frequency
// - gain live, stored only after yes
// - yes commits, no restores saved values
// - select after answer returns to readout
// - gain 0..50 dB, 1/10 dB steps
// - refuse gain pushing output outside -20..0 dBm
// - panel works while remote selected
// - alarm raised on synthesizer unlock
// - remote and mute LEDs follow selections
// - serial type: three standards, 9600 8N1
// - step sizes 1/10/100/125 kHz drive edits
// - unit address 00..31, multidrop only
`timescale 1ns/1ps
`default_nettype none
module front_panel_menu
    import panel_pkg::*;
#(
    parameter int        DEB_CYC   = DEBOUNCE_CYC,
    parameter int        IDLE_LIM  = IDLE_CYC,
    parameter int        PHASE_LIM = PHASE_CYC,
    parameter int        MUTE_LIM  = MUTE_CYC,
    parameter logic [15:0] FW_VERSION = 16'h0001  // arbitrary value
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic [SW_N-1:0] sw_raw,
    input  wire logic          pll_locked,
    input  wire settings_t     nv_data,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    output state_t             disp_mode,
    output logic [2:0]         disp_item,
    output logic [2:0]         disp_cursor,
    output logic               disp_yes,
    output settings_t          disp_set,
    output logic [15:0]        disp_version,
    output logic [21:0]        synth_freq_khz,
    output logic [5:0]         atten_gain_db,
    output logic               carrier_mute,
    output logic               led_alarm,
    output logic               led_remote,
    output logic               led_mute,
    output logic               nv_wr,
    output settings_t          nv_wdata
);

    // frequency increment for step size and cursor digit
    function automatic logic [21:0] fstep(input logic [1:0] s,
                                          input logic [2:0] c);
        logic [21:0] b;
        b = (s == 2'h0) ? 22'h00_0001 : (s == 2'h1) ? 22'h00_000A :
            (s == 2'h2) ? 22'h00_0064 : 22'h00_007D;
        unique case (c)
            3'h0:    fstep = b;
            3'h1:    fstep = 22'(b * 22'h00_000A);
            3'h2:    fstep = 22'(b * 22'h00_0064);
            default: fstep = 22'(b * 22'h00_03E8);
        endcase
    endfunction : fstep

    // gain legal for the present input level
    function automatic logic gain_ok(input logic [6:0] g,
                                     input logic signed [7:0] lvl);
        logic signed [9:0] o;
        o = 10'(lvl) + 10'(signed'({3'h0, g}));
        gain_ok = (g <= 7'(GAIN_MAX_DB)) && (o <= 10'(OUT_MAX_DBM))
                  && (o >= 10'(OUT_MIN_DBM));
    endfunction : gain_ok

    state_t          state_r;
    settings_t       live_r, saved_r;
    logic [2:0]      item_r, cursor_r;
    logic            yes_r, loaded_r, mute_sel_r;
    logic signed [7:0] level_r;
    logic [21:0]     applied_r;
    logic [31:0]     phase_cnt_r, idle_cnt_r, mute_cnt_r;
    logic [SW_N-1:0] deb_r, ev_r;
    logic [31:0]     deb_cnt_r [SW_N];
    logic            any_ev;
    logic            wr_pend_r;
    logic [7:0]      wr_addr_r;
    logic            commit, discard;

    assign any_ev = |ev_r;

    // debounce each switch and emit one pulse per press
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            deb_r <= '0;
            ev_r  <= '0;
            for (int i = 0; i < SW_N; i++) begin
                deb_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SW_N; i++) begin
                ev_r[i] <= 1'b0;
                if (sw_raw[i] == deb_r[i]) begin
                    deb_cnt_r[i] <= '0;
                end else if (deb_cnt_r[i] >= 32'(DEB_CYC - 1)) begin
                    deb_cnt_r[i] <= '0;
                    deb_r[i]     <= sw_raw[i];
                    ev_r[i]      <= sw_raw[i];
                end else begin
                    deb_cnt_r[i] <= deb_cnt_r[i] + 32'h0000_0001;
                end
            end
        end
    end

    // session end decisions
    always_comb begin
        commit  = (state_r == ST_PROMPT) && ev_r[SW_SEL] && yes_r;
        discard = ((state_r == ST_PROMPT) && ev_r[SW_SEL] && !yes_r)
                  || (((state_r == ST_MENU) || (state_r == ST_PROMPT))
                      && !any_ev
                      && (idle_cnt_r >= 32'(IDLE_LIM - 1)));
    end

    // idle timer, running only inside a session
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idle_cnt_r <= '0;
        end else if ((state_r != ST_MENU && state_r != ST_PROMPT)
                     || any_ev || discard) begin
            idle_cnt_r <= '0;
        end else begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
        end
    end

    // display sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r     <= ST_LAMP;
            phase_cnt_r <= '0;
            item_r      <= MI_FREQ;
            cursor_r    <= 3'h0;
            yes_r       <= 1'b0;
        end else begin
            unique case (state_r)
                ST_LAMP, ST_VER: begin
                    if (phase_cnt_r >= 32'(PHASE_LIM - 1)) begin
                        phase_cnt_r <= '0;
                        state_r <= (state_r == ST_LAMP) ? ST_VER
                                                        : ST_READ;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 32'h0000_0001;
                    end
                end
                ST_READ: begin
                    if (ev_r[SW_SEL]) begin
                        state_r  <= ST_MENU;
                        item_r   <= MI_FREQ;
                        cursor_r <= 3'h0;
                    end
                end
                ST_MENU: begin
                    if (discard) begin
                        state_r <= ST_READ;
                    end else if (ev_r[SW_SEL]) begin
                        cursor_r <= 3'h0;
                        yes_r    <= 1'b0;
                        if (cursor_r == CUR_RET || item_r == MI_ADDR) begin
                            state_r <= ST_PROMPT;
                        end else begin
                            item_r <= item_r + 3'h1;
                        end
                    end else if (ev_r[SW_RIGHT] && cursor_r != CUR_RET) begin
                        cursor_r <= cursor_r + 3'h1;
                    end else if (ev_r[SW_LEFT] && cursor_r != 3'h0) begin
                        cursor_r <= cursor_r - 3'h1;
                    end
                end
                ST_PROMPT: begin
                    if (commit || discard) begin
                        state_r <= (ev_r[SW_SEL]) ? ST_DONE : ST_READ;
                    end else if (ev_r[SW_UP] || ev_r[SW_DOWN]) begin
                        yes_r <= !yes_r;
                    end
                end
                ST_DONE: begin
                    if (ev_r[SW_SEL]) begin
                        state_r <= ST_READ;
                    end
                end
            endcase
        end
    end

    // working settings: edits, commit and restore
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            live_r   <= SET_RST;
            saved_r  <= SET_RST;
            loaded_r <= 1'b0;
            nv_wr    <= 1'b0;
            nv_wdata <= SET_RST;
        end else begin
            nv_wr <= 1'b0;
            if (!loaded_r) begin
                loaded_r <= 1'b1;
                live_r   <= nv_data;
                saved_r  <= nv_data;
            end else if (commit) begin
                saved_r  <= live_r;
                nv_wr    <= 1'b1;
                nv_wdata <= live_r;
            end else if (discard) begin
                live_r <= saved_r;
            end else if (state_r == ST_MENU && cursor_r != CUR_RET
                         && (ev_r[SW_UP] || ev_r[SW_DOWN])) begin
                unique case (item_r)
                    MI_FREQ: begin
                        if (ev_r[SW_UP]) begin
                            live_r.freq_khz <=
                                (live_r.freq_khz + fstep(live_r.step, cursor_r)
                                 > FREQ_MAX_KHZ) ? FREQ_MAX_KHZ :
                                live_r.freq_khz + fstep(live_r.step, cursor_r);
                        end else begin
                            live_r.freq_khz <=
                                (live_r.freq_khz - FREQ_MIN_KHZ
                                 < fstep(live_r.step, cursor_r)) ? FREQ_MIN_KHZ :
                                live_r.freq_khz - fstep(live_r.step, cursor_r);
                        end
                    end
                    MI_GAIN: begin
                        if (cursor_r <= 3'h1 && ev_r[SW_UP] &&
                            gain_ok({1'b0, live_r.gain_db}
                                    + ((cursor_r == 3'h0) ? 7'h01 : 7'h0A),
                                    level_r)) begin
                            live_r.gain_db <= live_r.gain_db +
                                ((cursor_r == 3'h0) ? 6'h01 : 6'h0A);
                        end else if (cursor_r <= 3'h1 && ev_r[SW_DOWN] &&
                            live_r.gain_db >= ((cursor_r == 3'h0) ? 6'h01 : 6'h0A)
                            && gain_ok({1'b0, live_r.gain_db}
                                - ((cursor_r == 3'h0) ? 7'h01 : 7'h0A),
                                level_r)) begin
                            live_r.gain_db <= live_r.gain_db -
                                ((cursor_r == 3'h0) ? 6'h01 : 6'h0A);
                        end
                    end
                    MI_REMOTE: live_r.remote <= !live_r.remote;
                    MI_SENSE:  live_r.invert <= !live_r.invert;
                    MI_EXTREF: live_r.extref <= !live_r.extref;
                    MI_STEP: begin
                        live_r.step <= ev_r[SW_UP] ? live_r.step + 2'h1
                                                   : live_r.step - 2'h1;
                    end
                    MI_SERIAL: begin
                        if (ev_r[SW_UP]) begin
                            live_r.serial <= (live_r.serial >= SER_LAST) ? 2'h0
                                             : live_r.serial + 2'h1;
                        end else begin
                            live_r.serial <= (live_r.serial == 2'h0) ? SER_LAST
                                             : live_r.serial - 2'h1;
                        end
                    end
                    MI_ADDR: begin
                        live_r.addr <= ev_r[SW_UP] ? live_r.addr + 5'h01
                                                   : live_r.addr - 5'h01;
                    end
                endcase
            end
        end
    end

    // synthesizer apply and frequency-change mute
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            applied_r  <= FREQ_RST_KHZ;
            mute_cnt_r <= '0;
        end else if (!loaded_r) begin
            applied_r <= nv_data.freq_khz;
        end else if (commit && live_r.freq_khz != applied_r) begin
            applied_r  <= live_r.freq_khz;
            mute_cnt_r <= 32'(MUTE_LIM);
        end else if (mute_cnt_r != '0) begin
            mute_cnt_r <= mute_cnt_r - 32'h0000_0001;
        end
    end

    // registered display and indicator outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            disp_mode      <= ST_LAMP;
            disp_item      <= MI_FREQ;
            disp_cursor    <= 3'h0;
            disp_yes       <= 1'b0;
            disp_set       <= SET_RST;
            disp_version   <= FW_VERSION;
            synth_freq_khz <= FREQ_RST_KHZ;
            atten_gain_db  <= 6'h00;
            carrier_mute   <= 1'b1;
            led_alarm      <= 1'b0;
            led_remote     <= 1'b0;
            led_mute       <= 1'b0;
        end else begin
            disp_mode      <= state_r;
            disp_item      <= item_r;
            disp_cursor    <= cursor_r;
            disp_yes       <= yes_r;
            disp_set       <= live_r;
            disp_version   <= FW_VERSION;
            synth_freq_khz <= applied_r;
            atten_gain_db  <= live_r.gain_db;
            carrier_mute   <= mute_sel_r || (mute_cnt_r != '0);
            led_alarm      <= !pll_locked;
            led_remote     <= live_r.remote;
            led_mute       <= mute_sel_r;
        end
    end

    // AHB-Lite slave: zero wait, always OKAY
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            mute_sel_r <= 1'b0;
            level_r    <= -8'sd40;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (wr_pend_r) begin
                unique case (wr_addr_r)
                    OFS_CTRL:  mute_sel_r <= hwdata[0];
                    OFS_LEVEL: level_r    <= signed'(hwdata[7:0]);
                    default:   ;
                endcase
            end
            wr_pend_r <= hsel && htrans[1] && hwrite && hready;
            wr_addr_r <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite && hready) begin
                unique case (haddr[7:0])
                    OFS_CTRL:    hrdata <= {31'h0, mute_sel_r};
                    OFS_STATUS:  hrdata <= {20'h0, cursor_r, item_r,
                                            2'h0, !pll_locked, state_r};
                    OFS_LEVEL:   hrdata <= {24'h0, level_r};
                    OFS_SAVED:   hrdata <= saved_r[39:8];
                    OFS_LIVE:    hrdata <= live_r[39:8];
                    OFS_VERSION: hrdata <= {16'h0, FW_VERSION};
                    default:     hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : front_panel_menu
`default_nettype wire

/* File: test/panel_sva.sv */
// panel_sva: port assertions for the front-panel menu controller
// assumes a bind onto front_panel_menu, one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module panel_sva
    import panel_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        pll_locked,
    input wire state_t      disp_mode,
    input wire logic [2:0]  disp_cursor,
    input wire settings_t   disp_set,
    input wire logic [21:0] synth_freq_khz,
    input wire logic [5:0]  atten_gain_db,
    input wire logic        carrier_mute,
    input wire logic        led_alarm,
    input wire logic        led_remote,
    input wire logic        nv_wr
);
    logic [1:0] up_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // edges since reset, masks the power-up load of the settings
    always_ff @(posedge clk or posedge reset) begin
        if (reset) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    property p_alarm; 1 |=> led_alarm == !$past(pll_locked); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm led wrong");
    property p_gain; atten_gain_db <= GAIN_MAX_DB && disp_set.gain_db <= GAIN_MAX_DB; endproperty
    a_gain: assert property (p_gain) else $error("gain above limit");
    property p_cur; disp_cursor <= CUR_RET; endproperty
    a_cur: assert property (p_cur) else $error("cursor out of range");
    property p_freq; up_r == 2'h3 && $changed(synth_freq_khz) |-> $past(nv_wr); endproperty
    a_freq: assert property (p_freq) else $error("freq applied unsaved");
    property p_mute; up_r == 2'h3 && $changed(synth_freq_khz) |-> ##[0:1] carrier_mute; endproperty
    a_mute: assert property (p_mute) else $error("carrier not muted");
    property p_save; nv_wr |-> disp_mode == ST_PROMPT ##1 disp_mode == ST_DONE && !nv_wr; endproperty
    a_save: assert property (p_save) else $error("store outside prompt");
    property p_lamp; $past(disp_mode) == ST_LAMP && disp_mode != ST_LAMP |-> disp_mode == ST_VER;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp test not to version");
    property p_ver; $past(disp_mode) == ST_VER && disp_mode != ST_VER |-> disp_mode == ST_READ;
    endproperty
    a_ver: assert property (p_ver) else $error("version not to readout");
    property p_menu; $past(disp_mode) == ST_MENU && disp_mode != ST_MENU
        |-> disp_mode inside {ST_PROMPT, ST_READ}; endproperty
    a_menu: assert property (p_menu) else $error("menu left wrongly");
    property p_done; $past(disp_mode) == ST_DONE && disp_mode != ST_DONE |-> disp_mode == ST_READ;
    endproperty
    a_done: assert property (p_done) else $error("done not to readout");
    property p_remote; $changed(disp_set.remote) |-> ##[0:1] led_remote == disp_set.remote;
    endproperty
    a_remote: assert property (p_remote) else $error("remote led wrong");
endmodule : panel_sva
`default_nettype wire

/* File: test/operator_model.sv */
// operator_model: presses one panel switch per request, then lets go
// assumes go pulses one cycle while busy is low; idle switches read low
`timescale 1ns/1ps
`default_nettype none
module operator_model
    import panel_pkg::*;
#(
    parameter int HOLD = 8
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       go,
    input  wire logic [2:0] key,
    output logic [SW_N-1:0] sw_raw,
    output logic            busy
);
    int cnt;
    // hold past the debounce time, then stay released as long
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_raw <= '0;
            busy   <= 1'b0;
            cnt    <= 0;
        end else if (go && !busy) begin
            sw_raw <= SW_N'(1) << key;
            busy   <= 1'b1;
            cnt    <= 2 * HOLD;
        end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == HOLD) sw_raw <= '0;
            if (cnt == 1) busy <= 1'b0;
        end
    end
endmodule : operator_model
`default_nettype wire

/* File: test/testbench.sv */
// testbench: AHB-Lite reads checked through a queue, panel via operator
// assumes panel_pkg, front_panel_menu, operator_model and panel_sva
`timescale 1ns/1ps
`default_nettype none
module testbench
    import panel_pkg::*;
;
    localparam logic [21:0] F0 = 22'h20_0B20; // 2100000 kHz
    localparam logic [21:0] F1 = 22'h20_0B2A; // one 10 kHz step up
    logic        clk = 1'b0, reset = 1'b1, pll_locked = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        go = 1'b0, rd_r = 1'b0, busy, hreadyout, hresp, disp_yes;
    logic        carrier_mute, led_alarm, led_remote, led_mute, nv_wr;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, m, seed;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, key = 3'h0, disp_item, disp_cursor;
    logic [4:0]  sw_raw;
    logic [15:0] disp_version;
    logic [21:0] synth_freq_khz;
    logic [5:0]  atten_gain_db;
    state_t      disp_mode;
    settings_t   disp_set, nv_wdata;
    settings_t   nv_data = '{F0, 6'h0A, 1'b0, 1'b0, 2'h1, 1'b0, 2'h0, 5'h03};
    int          bad_count = 0, check_count = 0, nv_n = 0, n, cyc = 0;
    logic [31:0] exp_q[$];
    front_panel_menu #(.DEB_CYC(4), .IDLE_LIM(200), .PHASE_LIM(10), .MUTE_LIM(5),
        .FW_VERSION(16'h00A5)) uut (.clk, .reset, .sw_raw, .pll_locked, .nv_data, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .disp_mode, .disp_item, .disp_cursor, .disp_yes, .disp_set, .disp_version,
        .synth_freq_khz, .atten_gain_db, .carrier_mute, .led_alarm, .led_remote, .led_mute,
        .nv_wr, .nv_wdata);
    operator_model #(.HOLD(8)) op (.clk, .reset, .go, .key, .sw_raw, .busy);
    // clock at 10 MHz
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    function automatic logic [31:0] lv(input logic [21:0] f, input logic [5:0] g, input logic r);
        return {f, g, r, 1'b0, 2'h1};
    endfunction : lv
    // one single transfer; a read notes its expected word in the queue
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_r   <= !w;
        if (!w) exp_q.push_back(d);
        k = 0;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        rd_r <= 1'b0;
    endtask : bus
    task automatic press(input int s);
        int k;
        @(posedge clk);
        go  <= 1'b1;
        key <= 3'(s);
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        do begin @(posedge clk); k++; end while (busy !== 1'b0 && k < 60);
        repeat (3) @(posedge clk);
    endtask : press
    // read data against the oldest note, store pulses, hang limit
    always @(posedge clk) begin
        cyc++;
        if (nv_wr === 1'b1) nv_n++;
        if (rd_r && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
        if (cyc == 6000) begin bad_count++; end_sim(); end
    end
    // power-up, menus, prompt answers, idle revert, indicators
    initial begin
        seed = 32'h235c;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, OFS_STATUS, 32'h0);
        bus(1'b0, OFS_SAVED, lv(F0, 6'h0A, 1'b0));
        bus(1'b0, OFS_VERSION, 32'h0000_00A5);
        bus(1'b1, 8'h18, $random(seed));
        bus(1'b0, 8'h18, 32'h0);
        bus(1'b1, OFS_LEVEL, 32'h0000_00E2); // input at -30 dBm
        bus(1'b0, OFS_LEVEL, 32'h0000_00E2);
        n = 0;
        while (disp_mode !== ST_READ && n < 100) begin @(posedge clk); n++; end
        press(SW_SEL);
        bus(1'b0, OFS_STATUS, 32'h0000_0003);
        press(SW_SEL);
        press(SW_UP);
        chk(32'(atten_gain_db), 32'h0000_000B);
        press(SW_RIGHT);
        press(SW_UP);
        press(SW_UP); // 31 dB would leave the output window
        bus(1'b0, OFS_LIVE, lv(F0, 6'h15, 1'b0));
        press(SW_SEL);
        press(SW_UP);
        press(SW_DOWN);
        press(SW_UP);
        chk(32'(led_remote), 32'h1);
        for (int i = 0; i < 5; i++) press(SW_RIGHT);
        bus(1'b0, OFS_STATUS, 32'h0000_0883);
        press(SW_SEL);
        chk(32'(disp_mode), 32'(ST_PROMPT));
        press(SW_UP);
        press(SW_SEL);
        bus(1'b0, OFS_SAVED, lv(F0, 6'h15, 1'b1));
        chk(32'(nv_n), 32'h1);
        press(SW_SEL);
        chk(32'(disp_mode), 32'(ST_READ));
        press(SW_SEL);
        press(SW_UP);
        bus(1'b0, OFS_LIVE, lv(F1, 6'h15, 1'b1));
        chk(32'(synth_freq_khz), 32'(F0));
        for (int i = 0; i < 7; i++) press(SW_SEL);
        bus(1'b0, OFS_STATUS, 32'h0000_01C3);
        press(SW_SEL);
        chk(32'(disp_mode), 32'(ST_PROMPT));
        press(SW_SEL);
        bus(1'b0, OFS_LIVE, lv(F0, 6'h15, 1'b1));
        press(SW_SEL);
        press(SW_SEL);
        press(SW_UP);
        for (int i = 0; i < 4; i++) press(SW_RIGHT);
        press(SW_SEL);
        press(SW_UP);
        press(SW_SEL);
        chk(32'(synth_freq_khz), 32'(F1));
        press(SW_SEL);
        press(SW_SEL);
        repeat (150) @(posedge clk);
        press(SW_UP);
        repeat (150) @(posedge clk);
        chk(32'(disp_mode), 32'(ST_MENU));
        repeat (80) @(posedge clk);
        chk(32'(disp_mode), 32'(ST_READ));
        bus(1'b0, OFS_LIVE, lv(F1, 6'h15, 1'b1));
        nv_data <= nv_wdata;
        reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        bus(1'b0, OFS_SAVED, lv(F1, 6'h15, 1'b1));
        pll_locked <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(led_alarm), 32'h1);
        m = $random(seed);
        bus(1'b1, OFS_CTRL, m);
        repeat (2) @(posedge clk);
        chk(32'(led_mute), 32'(m[0]));
        end_sim();
    end
endmodule : testbench
bind front_panel_menu panel_sva sva_i (.clk, .reset, .pll_locked, .disp_mode, .disp_cursor,
    .disp_set, .synth_freq_khz, .atten_gain_db, .carrier_mute, .led_alarm, .led_remote, .nv_wr);
`default_nettype wire
